//--- link_test_rx.sv
`timescale 1ns/10ps
`default_nettype none
module link_test_rx #(
    parameter int TELEGRAM_CYCLES = link_test_pkg::TELEGRAM_BITS * link_test_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    link_if.rx link,
    // Configuration
    input wire logic [1:0] arch_cfg,
    input wire logic [link_test_pkg::ANT_W-1:0] exp_ant,
    input wire logic [link_test_pkg::LINK_W-1:0] exp_link,
    input wire logic dist_tick,
    // Results
    output logic msg_valid,
    output logic [link_test_pkg::STR_W-1:0] msg_strength,
    output logic [31:0] msg_time,
    output logic [31:0] msg_odo,
    output logic test_ok,
    output logic test_err,
    output logic chan_failed,
    output logic [1:0] arch_q
);

    logic [link_test_pkg::FRAME_W-1:0] f;
    logic [31:0] time_q;
    logic [31:0] odo_q;
    logic [2:0] idx_q;
    logic bad_q;
    logic sent_q;
    logic [4:0] gap_q;
    logic [15:0] cyc_q;
    logic [7:0] nbits_q;
    logic [9:0] idle_q;
    logic seen_q;
    logic [9:0] run_q;
    logic flags_hi_q;
    logic cfg_done_q;
    logic fail_d;
    logic usable;

    assign f = link.frame;
    assign usable = !f[link_test_pkg::POS_FOREIGN] && !f[link_test_pkg::POS_LTEST]
        && !f[link_test_pkg::POS_UNAVAIL];

    ////////////////////////////////////////////////////////////////////////////
    // architecture latched once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arch_q <= 2'h0;
            cfg_done_q <= 1'b0;
        end
        else if (!cfg_done_q)
        begin
            arch_q <= arch_cfg;
            cfg_done_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            time_q <= 32'h0;
            odo_q <= 32'h0;
        end
        else
        begin
            time_q <= time_q + 32'h1;
            if (dist_tick)
                odo_q <= odo_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link test checking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idx_q <= 3'h0;
            bad_q <= 1'b0;
            test_ok <= 1'b0;
            test_err <= 1'b0;
        end
        else
        begin
            test_ok <= 1'b0;
            test_err <= 1'b0;
            if (link.frame_strobe)
            begin
                if (!f[link_test_pkg::POS_LTEST])
                begin
                    idx_q <= 3'h0;
                    bad_q <= 1'b0;
                    test_err <= idx_q != 3'h0 && idx_q < 3'(link_test_pkg::MAND_BITS);
                end
                else if (idx_q < 3'(link_test_pkg::MAND_BITS))
                begin
                    idx_q <= idx_q + 3'h1;
                    if (f != link_test_pkg::mand_frame(idx_q[1:0], exp_ant, exp_link))
                        bad_q <= 1'b1;
                    if (idx_q == 3'(link_test_pkg::MAND_BITS - 1))
                    begin
                        test_ok <= !bad_q && f == link_test_pkg::mand_frame(2'h3,
                            exp_ant, exp_link);
                        test_err <= bad_q || f != link_test_pkg::mand_frame(2'h3,
                            exp_ant, exp_link);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one message per passage, foreign data dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sent_q <= 1'b0;
            gap_q <= 5'h0;
            msg_valid <= 1'b0;
            msg_strength <= '0;
            msg_time <= 32'h0;
            msg_odo <= 32'h0;
        end
        else
        begin
            msg_valid <= 1'b0;
            if (link.frame_strobe && usable)
            begin
                if (!f[link_test_pkg::POS_DETECT])
                begin
                    gap_q <= 5'h0;
                    if (!sent_q)
                    begin
                        sent_q <= 1'b1;
                        msg_valid <= 1'b1;
                        msg_strength <= f[link_test_pkg::POS_STR +: link_test_pkg::STR_W];
                        msg_time <= time_q;
                        msg_odo <= odo_q;
                    end
                end
                else if (gap_q == 5'(link_test_pkg::PASSAGE_GAP - 1))
                    sent_q <= 1'b0;
                else
                    gap_q <= gap_q + 5'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel supervision
    always_comb
    begin
        fail_d = 1'b0;
        if (seen_q && idle_q == 10'(link_test_pkg::IDLE_TIMEOUT))
            fail_d = 1'b1;
        if (run_q > 10'(link_test_pkg::FAIL_DIST_CM))
            fail_d = 1'b1;
        if (link.frame_strobe && nbits_q == 8'(link_test_pkg::TELEGRAM_BITS - 1)
            && (cyc_q > 16'(TELEGRAM_CYCLES + link_test_pkg::RATE_TOL)
            || cyc_q + 16'(link_test_pkg::RATE_TOL) < 16'(TELEGRAM_CYCLES)))
            fail_d = 1'b1;
        if (link.frame_strobe && usable && arch_q == 2'h0
            && f[link_test_pkg::POS_LINK +: link_test_pkg::LINK_W] != exp_link)
            fail_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc_q <= 16'h0;
            nbits_q <= 8'h0;
            idle_q <= 10'h0;
            seen_q <= 1'b0;
            run_q <= 10'h0;
            flags_hi_q <= 1'b0;
            chan_failed <= 1'b0;
        end
        else
        begin
            if (fail_d)
                chan_failed <= 1'b1;
            if (link.frame_strobe)
            begin
                seen_q <= 1'b1;
                idle_q <= 10'h0;
                flags_hi_q <= !usable;
                if (usable)
                    run_q <= 10'h0;
                if (nbits_q == 8'(link_test_pkg::TELEGRAM_BITS - 1) || !seen_q)
                begin
                    nbits_q <= 8'h0;
                    cyc_q <= 16'h1;
                end
                else
                begin
                    nbits_q <= nbits_q + 8'h1;
                    cyc_q <= cyc_q + 16'h1;
                end
            end
            else
            begin
                cyc_q <= cyc_q + 16'h1;
                if (seen_q && idle_q != 10'(link_test_pkg::IDLE_TIMEOUT))
                    idle_q <= idle_q + 10'h1;
            end
            if (flags_hi_q && dist_tick && run_q != 10'h3FF && !(link.frame_strobe && usable))
                run_q <= run_q + 10'h1;
        end
    end

endmodule
`default_nettype wire

//--- link_test_pkg.sv
`default_nettype none
package link_test_pkg;

    // Frame layout: info bits then check bits
    localparam int STR_W = 4;
    localparam int ANT_W = 2;
    localparam int LINK_W = 2;
    localparam int INFO_W = 13;
    localparam int CRC_W = 8;
    localparam int FRAME_W = 21;
    localparam int POS_DETECT = 0;
    localparam int POS_DECODE = 1;
    localparam int POS_UNAVAIL = 2;
    localparam int POS_FOREIGN = 3;
    localparam int POS_LTEST = 4;
    localparam int POS_STR = 5;
    localparam int POS_ANT = 9;
    localparam int POS_LINK = 11;
    localparam int POS_CRC = 13;
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
    localparam logic [CRC_W-1:0] CRC_INIT = 8'hFF;

    // Test pattern contents
    localparam int MAND_BITS = 4;
    localparam int EXT_MAX = 15;
    localparam logic [STR_W-1:0] STR_LOW = 4'h0;
    localparam logic [STR_W-1:0] STR_HIGH = 4'hF;
    localparam logic [STR_W-1:0] STR_ALT = 4'h5;

    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BIT_RATE = 50_000;
    localparam int BIT_CYCLES = CLK_HZ / BIT_RATE;
    localparam int TEST_MIN_MS = 500;
    localparam int TEST_MAX_MS = 1000;
    localparam int TEST_MIN_BITS = (BIT_RATE * TEST_MIN_MS + 999) / 1000;
    localparam int TEST_MAX_BITS = (BIT_RATE * TEST_MAX_MS) / 1000;
    localparam int IDLE_TIMEOUT = 2 * BIT_CYCLES;
    localparam int TELEGRAM_BITS = 128;
    localparam int RATE_TOL = BIT_CYCLES / 2;
    localparam int PASSAGE_GAP = 16;
    localparam int FAIL_DIST_CM = 500;

    // Register map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_ON = 0;
    localparam int CTRL_PERM = 1;
    localparam int CTRL_UNAVAIL = 2;
    localparam int CTRL_FOREIGN = 3;
    localparam int CTRL_EXT = 4;
    localparam int CTRL_ANT = 8;
    localparam int CTRL_LINK = 10;
    localparam int STAT_TEST = 0;
    localparam int STAT_HALT = 1;
    localparam int STAT_COUNT = 8;

    function automatic logic [CRC_W-1:0] crc8(input logic [INFO_W-1:0] d);
        logic [CRC_W-1:0] c;
        c = CRC_INIT;
        for (int i = INFO_W - 1; i >= 0; i--)
        begin
            if (c[CRC_W-1] ^ d[i])
                c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[CRC_W-2:0], 1'b0};
        end
        return c;
    endfunction

    function automatic logic [INFO_W-1:0] pack_info(
        input logic [4:0] flags,
        input logic [STR_W-1:0] str,
        input logic [ANT_W-1:0] ant,
        input logic [LINK_W-1:0] link
    );
        return {link, ant, str, flags};
    endfunction

    // Flags ordered {ltest, foreign, unavail, decode, detect}
    function automatic logic [FRAME_W-1:0] seal(input logic [INFO_W-1:0] info,
                                                input logic bad);
        logic [CRC_W-1:0] c;
        c = bad ? crc8(~info) : crc8(info);
        return {c, info};
    endfunction

    function automatic logic [FRAME_W-1:0] mand_frame(
        input logic [1:0] slot,
        input logic [ANT_W-1:0] ant,
        input logic [LINK_W-1:0] link
    );
        logic [FRAME_W-1:0] f;
        f = '0;
        unique case (slot)
            2'h0: f = seal(pack_info(5'h10, STR_LOW, ant, link), 1'b0);
            2'h1: f = seal(pack_info(5'h10, STR_LOW, ant, link), 1'b1);
            2'h2: f = seal(pack_info(5'h1F, STR_HIGH, ~ant, ~link), 1'b0);
            2'h3: f = seal(pack_info(5'h1A, STR_ALT, ant, link), 1'b0);
        endcase
        return f;
    endfunction

endpackage
`default_nettype wire

//--- link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface link_if;
    logic frame_strobe;
    logic [link_test_pkg::FRAME_W-1:0] frame;
    logic line_coding;

    modport tx (output frame_strobe, output frame, output line_coding);
    modport rx (input frame_strobe, input frame, input line_coding);
endinterface
`default_nettype wire

//--- link_test_tx.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Regular link tests of four mandatory frames
// - Up to fifteen optional extension frames
// - Link test flag covers whole test
// - Bit 1 flags low, strength 0000
// - Bit 2 like bit 1, CRC wrong
// - Bit 3 all ones, IDs inverted
// - Bit 4 pattern 11010, strength 0101
// - Bad CRC over inverted info bits
// - Permanent failure silences link entirely
// - Unavailability flag marks temporary loss
// - Status flags carried in every frame outside link tests
// - Prefer testing outside balise contact
// - Receiver drops bits under foreign flag
// - Receiver evaluates one message per passage
// - Receiver stamps time and odometer itself
// - Single or redundant channels, receiver configured
// - Test interval between 0.5 and 1 s
// - Receiver checks 50 kbit/s rate
// - Receiver fails channel after 5 m stuck flags
module link_test_tx #(
    parameter int TEST_MIN_BITS = link_test_pkg::TEST_MIN_BITS,
    parameter int TEST_MAX_BITS = link_test_pkg::TEST_MAX_BITS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Balise data from the receive chain
    input wire logic detect_in,
    input wire logic decode_in,
    input wire logic [link_test_pkg::STR_W-1:0] strength_in,
    input wire logic contact_in,
    // Link
    link_if.tx link
);

    typedef enum logic [1:0] {ST_NORMAL, ST_TEST, ST_HALT} tx_state_e;

    tx_state_e state_q;
    tx_state_e state_d;
    logic [31:0] ctrl_q;
    logic [7:0] tests_q;
    logic [8:0] bit_cnt_q;
    logic [15:0] since_q;
    logic [4:0] idx_q;
    logic [4:0] idx_d;
    logic [4:0] len_q;
    logic tick;
    logic starting;
    logic [link_test_pkg::FRAME_W-1:0] frame_d;
    logic tx_on;
    logic perm;
    logic [link_test_pkg::ANT_W-1:0] ant;
    logic [link_test_pkg::LINK_W-1:0] lnk;
    logic [3:0] ext;
    logic apb_done;

    assign tx_on = ctrl_q[link_test_pkg::CTRL_ON];
    assign perm = ctrl_q[link_test_pkg::CTRL_PERM];
    assign ant = ctrl_q[link_test_pkg::CTRL_ANT +: link_test_pkg::ANT_W];
    assign lnk = ctrl_q[link_test_pkg::CTRL_LINK +: link_test_pkg::LINK_W];
    assign ext = ctrl_q[link_test_pkg::CTRL_EXT +: 4];
    assign tick = bit_cnt_q == 9'(link_test_pkg::BIT_CYCLES - 1);
    assign apb_done = psel && penable && pready;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= paddr != link_test_pkg::CTRL_OFS && paddr != link_test_pkg::STAT_OFS;
            prdata <= 32'h0;
            if (!pwrite && paddr == link_test_pkg::CTRL_OFS)
                prdata <= ctrl_q;
            if (!pwrite && paddr == link_test_pkg::STAT_OFS)
            begin
                prdata[link_test_pkg::STAT_TEST] <= state_q == ST_TEST;
                prdata[link_test_pkg::STAT_HALT] <= state_q == ST_HALT;
                prdata[link_test_pkg::STAT_COUNT +: 8] <= tests_q;
            end
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Write lands on the completing edge only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= link_test_pkg::CTRL_RST;
        else if (apb_done && pwrite && paddr == link_test_pkg::CTRL_OFS)
            ctrl_q <= {20'h0, pwdata[11:0]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit period timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bit_cnt_q <= 9'h0;
        else if (tick)
            bit_cnt_q <= 9'h0;
        else
            bit_cnt_q <= bit_cnt_q + 9'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test scheduling and frame selection
    always_comb
    begin
        state_d = state_q;
        idx_d = idx_q;
        starting = 1'b0;
        if (perm || !tx_on)
            state_d = ST_HALT;
        else if (state_q == ST_TEST && idx_q + 5'h1 < len_q)
            idx_d = idx_q + 5'h1;
        else if ((since_q >= 16'(TEST_MIN_BITS) && !contact_in)
            || since_q >= 16'(TEST_MAX_BITS - 1))
        begin
            starting = 1'b1;
            state_d = ST_TEST;
            idx_d = 5'h0;
        end
        else
            state_d = ST_NORMAL;
    end

    always_comb
    begin
        frame_d = link_test_pkg::seal(link_test_pkg::pack_info(
            {1'b0, ctrl_q[link_test_pkg::CTRL_FOREIGN], ctrl_q[link_test_pkg::CTRL_UNAVAIL],
             decode_in, detect_in}, strength_in, ant, lnk), 1'b0);
        if (state_d == ST_TEST)
        begin
            if (idx_d < 5'(link_test_pkg::MAND_BITS))
                frame_d = link_test_pkg::mand_frame(idx_d[1:0], ant, lnk);
            else
                frame_d = link_test_pkg::seal(link_test_pkg::pack_info(
                    {3'h4, decode_in, detect_in}, strength_in, ant, lnk), 1'b0);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_HALT;
            idx_q <= 5'h0;
            len_q <= 5'(link_test_pkg::MAND_BITS);
            since_q <= 16'h0;
            tests_q <= 8'h0;
        end
        else if (tick)
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            if (starting)
            begin
                len_q <= 5'(link_test_pkg::MAND_BITS) + {1'b0, ext};
                since_q <= 16'h0;
                tests_q <= tests_q + 8'h1;
            end
            else if (since_q != 16'hFFFF)
                since_q <= since_q + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link drive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link.frame_strobe <= 1'b0;
            link.frame <= '0;
            link.line_coding <= 1'b0;
        end
        else
        begin
            link.frame_strobe <= 1'b0;
            // no frames, no transitions when halted
            // one frame per bit period, in order
            if (tick && state_d != ST_HALT)
            begin
                link.frame_strobe <= 1'b1;
                link.frame <= frame_d;
                link.line_coding <= !link.line_coding;
            end
        end
    end

endmodule
`default_nettype wire

//--- link_test_pattern_gen_props.sv
`timescale 1ns/10ps
`default_nettype none
module link_test_pattern_gen_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic frame_strobe,
    input wire logic [link_test_pkg::FRAME_W-1:0] frame,
    input wire logic line_coding
);
    localparam int BIT = link_test_pkg::BIT_CYCLES;
    logic [15:0] gap_q;
    logic seen_q;
    logic [4:0] run_q;
    logic [12:0] info_q;
    logic [7:0] crc_q;

    ////////////////////////////////////////////////////////////////////////
    // Gap since last frame, for period checks across halts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_q <= 16'h0;
        else if (frame_strobe)
            gap_q <= 16'h0;
        else
            gap_q <= gap_q + 16'h1;
    end

    // Run of test frames and previous frame contents
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_q <= 1'b0;
            run_q <= 5'h0;
            info_q <= 13'h0;
            crc_q <= 8'h0;
        end
        else if (frame_strobe)
        begin
            seen_q <= 1'b1;
            run_q <= frame[4] ? run_q + 5'h1 : 5'h0;
            info_q <= frame[12:0];
            crc_q <= frame[20:13];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_strobe_single: assert property (frame_strobe |=> !frame_strobe)
        else $error("frame strobe longer than one cycle");
    a_strobe_period: assert property (frame_strobe && seen_q |-> ((int'(gap_q) + 1) % BIT) == 0)
        else $error("frame spacing not a whole bit period");
    a_line_toggle: assert property (frame_strobe |-> line_coding != $past(line_coding))
        else $error("line coding did not toggle with frame");
    a_line_quiet: assert property (!frame_strobe |-> $stable(line_coding))
        else $error("line coding moved without a frame");
    a_frame_hold: assert property (!frame_strobe |-> $stable(frame))
        else $error("frame changed between strobes");
    a_bit_one: assert property (frame_strobe && frame[4] && run_q == 5'h0 |-> frame[8:0] == 9'h010)
        else $error("first test frame contents wrong");
    a_bit_two: assert property (frame_strobe && run_q == 5'h1 |->
        frame[4] && frame[12:0] == info_q && frame[20:13] != crc_q)
        else $error("second test frame not a corrupted repeat");
    a_bit_three: assert property (frame_strobe && run_q == 5'h2 |->
        frame[8:0] == 9'h1FF && frame[12:9] == ~info_q[12:9])
        else $error("third test frame contents wrong");
    a_bit_four: assert property (frame_strobe && run_q == 5'h3 |->
        frame[8:0] == 9'h0BA && frame[12:9] == ~info_q[12:9])
        else $error("fourth test frame contents wrong");
    a_test_bounded: assert property (frame_strobe && frame[4] |-> run_q <= 5'd18)
        else $error("link test longer than nineteen frames");

    c_four_done: cover property (frame_strobe && run_q == 5'h3);
    c_full_ext: cover property (frame_strobe && frame[4] && run_q == 5'd18);
    c_unavail: cover property (frame_strobe && frame[2] && !frame[4]);
endmodule
`default_nettype wire

//--- link_test_pattern_gen_test.sv
`timescale 1ns/10ps
`default_nettype none
module link_test_pattern_gen_test;
    localparam int MINB = 20;
    localparam int MAXB = 40;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic detect_in, decode_in, contact_in, msg_valid, test_ok, test_err, lt_prev, cf;
    logic [3:0] strength_in;
    logic [1:0] ant, lnk;
    logic [20:0] fq[$];
    int starts, oks, errs, msgs, since, miscompares, n_checks;

    link_if link_bus();
    link_test_tx #(.TEST_MIN_BITS(MINB), .TEST_MAX_BITS(MAXB)) link_test_tx_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .detect_in(detect_in), .decode_in(decode_in), .strength_in(strength_in),
        .contact_in(contact_in), .link(link_bus));
    link_test_rx link_test_rx_inst (
        .pclk(pclk), .presetn(presetn), .link(link_bus), .arch_cfg(2'h0), .exp_ant(ant),
        .exp_link(lnk), .dist_tick(1'b0), .msg_valid(msg_valid), .msg_strength(),
        .msg_time(), .msg_odo(), .test_ok(test_ok), .test_err(test_err), .chan_failed(cf),
        .arch_q());
    link_test_pattern_gen_props link_test_pattern_gen_props_inst (
        .pclk(pclk), .presetn(presetn), .frame_strobe(link_bus.frame_strobe),
        .frame(link_bus.frame), .line_coding(link_bus.line_coding));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Frame as the far end must see it; bad selects the inverted-info check
    function automatic logic [20:0] mk(input logic [4:0] fl, input logic [3:0] s,
                                       input logic [3:0] ids, input logic bad);
        logic [12:0] i;
        logic [12:0] d;
        logic [7:0] c;
        i = {ids, s, fl};
        d = bad ? ~i : i;
        c = 8'hFF;
        for (int k = 12; k >= 0; k--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
        return {c, i};
    endfunction

    task automatic pop(output logic [20:0] f);
        int n;
        n = 0;
        while (fq.size() == 0 && n < 1000)
        begin
            @(posedge pclk);
            n++;
        end
        if (fq.size() == 0)
        begin
            miscompares++;
            tally_and_finish();
        end
        else
        begin
            f = fq.pop_front();
            since++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Values seen at the edge, before that edge's updates land
    always @(posedge pclk)
    begin
        if (link_bus.frame_strobe === 1'b1)
        begin
            fq.push_back(link_bus.frame);
            if (link_bus.frame[4] && !lt_prev)
                starts++;
            lt_prev = link_bus.frame[4];
        end
        oks += int'(test_ok === 1'b1);
        errs += int'(test_err === 1'b1);
        msgs += int'(msg_valid === 1'b1);
    end

    initial
    begin
        logic [20:0] f;
        logic [31:0] rd;
        logic [31:0] up;
        logic err, unav, forn, lc;
        logic [3:0] ext;
        int gap, m0;
        {psel, penable, pwrite, paddr, pwdata, lt_prev} = '0;
        {detect_in, decode_in, strength_in, contact_in, presetn} = '0;
        rd = $urandom(32'h8cff);
        ant = 2'($urandom);
        lnk = 2'($urandom);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Corner rounds: detect run, unavailable, foreign, passage, extensions, contact
        for (int r = 0; r < 7; r++)
        begin
            ext = (r == 4) ? 4'hF : (r == 5) ? 4'($urandom_range(1, 14)) : 4'h0;
            unav = (r == 2);
            forn = (r == 3);
            detect_in <= (r == 1) ? 1'b1 : (r == 3 || r == 4) ? 1'b0 : 1'($urandom);
            decode_in <= 1'($urandom);
            strength_in <= 4'($urandom);
            contact_in <= (r == 6);
            apb(1'b1, 12'h000, {20'h0, lnk, ant, ext, forn, unav, 2'b01}, rd, err);
            m0 = msgs;
            f = '0;
            for (int n = 0; n < 60 && f[4] !== 1'b1; n++)
                pop(f);
            gap = since;
            since = 0;
            if (r > 0)
                check(32'(gap >= MINB && gap <= MAXB), 32'h1);
            if (r == 6)
                check(32'(gap >= MAXB - 2), 32'h1);
            for (int s = 0; s < 4; s++)
            begin
                if (s > 0)
                    pop(f);
                check(32'(f), 32'(mk((s == 2) ? 5'h1F : (s == 3) ? 5'h1A : 5'h10,
                    (s == 2) ? 4'hF : (s == 3) ? 4'h5 : 4'h0,
                    {lnk, ant} ^ {4{s == 2}}, s == 1)));
            end
            for (int e = 0; e < int'(ext); e++)
            begin
                pop(f);
                check(32'(f), 32'(mk({3'b100, decode_in, detect_in}, strength_in, {lnk, ant}, 1'b0)));
            end
            pop(f);
            check(32'(f), 32'(mk({1'b0, forn, unav, decode_in, detect_in}, strength_in,
                {lnk, ant}, 1'b0)));
            if (r == 3)
                check(32'(msgs), 32'(m0));
            if (r == 4)
                check(32'(msgs), 32'(m0 + 1));
        end
        check(32'(oks), 32'(starts));
        check(32'(errs), 32'h0);
        check(32'(cf), 32'h0);
        apb(1'b0, 12'h004, 32'h0, rd, err);
        check({16'h0, rd[15:0]}, {16'h0, starts[7:0], 8'h00});
        up = {20'($urandom), lnk, ant, 8'h01};
        apb(1'b1, 12'h000, up, rd, err);
        apb(1'b0, 12'h000, 32'h0, rd, err);
        check(rd, {20'h0, up[11:0]});
        apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, rd, err);
        check(32'(err), 32'h1);
        apb(1'b0, 12'h008, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h1);
        // Permanent failure: let two bit periods pass, then expect silence
        apb(1'b1, 12'h000, {20'h0, lnk, ant, 8'h03}, rd, err);
        repeat (800) @(posedge pclk);
        fq.delete();
        lc = link_bus.line_coding;
        repeat (1200) @(posedge pclk);
        check(32'(fq.size()), 32'h0);
        check(32'(link_bus.line_coding), 32'(lc));
        apb(1'b0, 12'h004, 32'h0, rd, err);
        check(32'(rd[1:0]), 32'h2);
        check(32'(cf), 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
